// file: rtl/wss_defs.svh
// register map, field positions and reset values of the wake and switch status bank
`ifndef WSS_DEFS_SVH
`define WSS_DEFS_SVH

// register addresses (7-bit)
`define WSS_ADDR_WAKE_A   7'h46
`define WSS_ADDR_WAKE_B   7'h47
`define WSS_ADDR_LEVEL    7'h48
`define WSS_ADDR_OVERLOAD 7'h54
`define WSS_ADDR_OPENLOAD 7'h55

// implemented-bit masks; reserved bits read zero
`define WSS_MASK_WAKE_A   8'h77
`define WSS_MASK_WAKE_B   8'h30
`define WSS_MASK_LEVEL    8'hF7
`define WSS_MASK_FAULT    8'h0F

// field positions
`define WSS_BIT_LIN_WAKE   6
`define WSS_BIT_CAN_WAKE   5
`define WSS_BIT_TIMER_WAKE 4
`define WSS_BIT_GP2_WAKE   5
`define WSS_BIT_GP1_WAKE   4
`define WSS_BIT_DEV_MODE   7
`define WSS_BIT_INT_PULLUP 6
`define WSS_BIT_GP1_LVL    4
`define WSS_BIT_LVL_RSVD   3
`define WSS_BIT_HV1_LVL    0

// reset values
`define WSS_RST_FLAGS     8'h00
`define WSS_RST_LEVEL     8'h00

`endif

// file: rtl/wss_pkg.sv
// types shared by the wake and switch status bank
package wss_pkg;

  // one-cycle wake event pulses from the mode controller
  typedef struct packed {
    logic       lin;
    logic       can;
    logic       timer;
    logic [2:0] hv;
    logic [1:0] gp;
  } wss_wake_ev_t;

  // per-switch fault detector levels
  typedef struct packed {
    logic [3:0] overload;
    logic [3:0] open_load;
  } wss_fault_t;

endpackage : wss_pkg

// file: rtl/wss_bank.sv
// wake source, input level and high-side fault status registers
//
// What this block does
// - uv comparator enable follows the CAN mode control bit being one.
// - all reserved bits of these registers read as zero.
// - bit 6 of first wake register latches a LIN wake-up.
// - bits 2..0 of first wake register latch wake inputs 3..1.
// - wake out of fail-safe sets the source flag like a normal wake.
// - bits 5,4 of second wake register latch gp pin 2,1 wakes.
// - level bit 7 shows development mode selected by the test pin.
// - level bit 6 shows the interrupt pin pull-up configuration.
// - level bits 5,4 show gp pin 2,1 levels when used as gp.
// - level bits 2..0 show wake input 3..1 levels, bit 3 zero.
// - gp level refreshed in normal/stop when wake, low- or high-side.
// - cyclic-sensed wake input level updates only at sampling instants.
// - gp pins never use the cyclic sampled update.
// - gp level refreshed only while the pin is configured as gp (gp_is_gpio set).
// - overload register bits 3..0 latch switch 4..1 overcurrent/overtemp.
// - open-load register bits 3..0 latch switch 4..1 open load.
// - overload flags may be raised spuriously at low supply.
// - reset clears wake flags; restart keeps them, reserved bits zero.
// - reset clears fault registers; restart keeps the four flags.
// - sleep request with wake flags set is reported as sleep restart.
`timescale 1ns/1ps

module wss_bank
  import wss_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         soft_rst,
  // register read port from the serial control port
  input  wire logic         reg_rd,
  input  wire logic [6:0]   reg_addr,
  output logic [7:0]        reg_rdata_r,
  output logic              reg_rvalid_r,
  // wake events and faults
  input  wire wss_wake_ev_t wake_ev,
  input  wire wss_fault_t   fault,
  // pin levels and pin configuration
  input  wire logic         fail_output_test_pin,
  input  wire logic         interrupt_pullup_config,
  input  wire logic [2:0]   hv_pin_level,
  input  wire logic [2:0]   hv_cyclic,
  input  wire logic [2:0]   hv_sample,
  input  wire logic [1:0]   gp_pin_level,
  input  wire logic [1:0]   gp_is_gpio,
  input  wire logic [1:0]   gp_level_cfg,
  input  wire logic         mode_normal_or_stop,
  // mode control
  input  wire logic         can_mode_bit,
  input  wire logic         sleep_req,
  output logic              can_uv_comp_en_r,
  output logic              sleep_ok_r,
  output logic              sleep_restart_r
);

`include "wss_defs.svh"

  // every check samples on the rising clock and rests while reset is high
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  // clear-on-read update: a set in the read cycle survives the clear
  function automatic logic [7:0] cor_next(input logic [7:0] cur,
                                          input logic [7:0] set,
                                          input logic       hit,
                                          input logic [7:0] mask);
    cor_next = (((hit ? 8'h00 : cur)) | set) & mask;
  endfunction : cor_next

  // ---------------------------------------------------------------
  // wake and fault flags
  // ---------------------------------------------------------------

  logic [7:0] wake_a_r;
  logic [7:0] wake_b_r;
  logic [7:0] overload_r;
  logic [7:0] open_load_r;
  logic [7:0] level_r;
  logic [7:0] wake_a_set;
  logic [7:0] wake_b_set;
  logic [7:0] overload_set;
  logic [7:0] open_load_set;
  logic       hit_a;
  logic       hit_b;
  logic       hit_ovl;
  logic       hit_ol;

  // event sources; fail-safe wakes arrive on the same pulses
  assign wake_a_set = {1'b0, wake_ev.lin, wake_ev.can, wake_ev.timer,
                       1'b0, wake_ev.hv};
  assign wake_b_set = {2'b00, wake_ev.gp, 4'h0};
  // detector levels; low-supply glitches are latched like real faults
  assign overload_set  = {4'h0, fault.overload};
  assign open_load_set = {4'h0, fault.open_load};

  // read hits that trigger the clear
  assign hit_a   = reg_rd && (reg_addr == `WSS_ADDR_WAKE_A);
  assign hit_b   = reg_rd && (reg_addr == `WSS_ADDR_WAKE_B);
  assign hit_ovl = reg_rd && (reg_addr == `WSS_ADDR_OVERLOAD);
  assign hit_ol  = reg_rd && (reg_addr == `WSS_ADDR_OPENLOAD);

  // wake flags; power-on reset, soft reset and a read clear them, restart has no path here
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_a_r <= `WSS_RST_FLAGS;
      wake_b_r <= `WSS_RST_FLAGS;
    end
    else if (soft_rst)
    begin
      wake_a_r <= `WSS_RST_FLAGS;
      wake_b_r <= `WSS_RST_FLAGS;
    end
    else
    begin
      wake_a_r <= cor_next(wake_a_r, wake_a_set, hit_a, `WSS_MASK_WAKE_A);
      wake_b_r <= cor_next(wake_b_r, wake_b_set, hit_b, `WSS_MASK_WAKE_B);
    end
  end

  // a flag stays up until read or soft reset; soft reset may cut it short
  chk_lin_wake: assert property (
    (wake_ev.lin || (wake_a_r[`WSS_BIT_LIN_WAKE] && !hit_a)) && !soft_rst
      |=> wake_a_r[`WSS_BIT_LIN_WAKE])
    else $error("lin wake flag not held until read");

  chk_hv_wake: assert property (
    wake_ev.hv[2] && !soft_rst |=> wake_a_r[2])
    else $error("wake input 3 flag not latched");

  chk_gp_wake: assert property (
    wake_ev.gp[1] && !soft_rst |=> wake_b_r[`WSS_BIT_GP2_WAKE])
    else $error("gp pin 2 wake flag not latched");

  chk_read_clear: assert property (
    hit_a && !soft_rst |=> reg_rdata_r == $past(wake_a_r)
                        && wake_a_r == ($past(wake_a_set) & `WSS_MASK_WAKE_A))
    else $error("clear-on-read returned or cleared wrongly");

  chk_soft_clear: assert property (
    soft_rst |=> wake_a_r == 8'h00 && overload_r == 8'h00 && open_load_r == 8'h00)
    else $error("soft reset left flags set");

  cov_wake_read: cover property (wake_ev.can ##[1:20] hit_a);
  cov_soft_event: cover property (soft_rst && (|wake_ev));

  // high-side fault flags
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      overload_r  <= `WSS_RST_FLAGS;
      open_load_r <= `WSS_RST_FLAGS;
    end
    else if (soft_rst)
    begin
      overload_r  <= `WSS_RST_FLAGS;
      open_load_r <= `WSS_RST_FLAGS;
    end
    else
    begin
      overload_r  <= cor_next(overload_r, overload_set, hit_ovl, `WSS_MASK_FAULT);
      open_load_r <= cor_next(open_load_r, open_load_set, hit_ol, `WSS_MASK_FAULT);
    end
  end

  // a latched fault only goes away through a read or a soft reset
  chk_fault_latch: assert property (
    fault.overload[2] && !soft_rst
      |=> overload_r[2] ##1 (overload_r[2] || $past(hit_ovl) || $past(soft_rst)))
    else $error("overload flag lost without a read");

  chk_open_load: assert property (
    fault.open_load[3] && !soft_rst |=> open_load_r[3])
    else $error("open-load flag not latched");

  chk_ovl_read: assert property (
    hit_ovl && !soft_rst |=> reg_rdata_r == $past(overload_r))
    else $error("overload read returned wrong value");

  cov_set_on_clear: cover property (hit_ol && fault.open_load[0]);

  // ---------------------------------------------------------------
  // input level mirror
  // ---------------------------------------------------------------

  // next value of the mirror, built bit by bit
  logic [7:0] level_nxt;

  // configuration pins follow the live level every cycle
  assign level_nxt[`WSS_BIT_DEV_MODE]   = fail_output_test_pin;
  assign level_nxt[`WSS_BIT_INT_PULLUP] = interrupt_pullup_config;
  assign level_nxt[`WSS_BIT_LVL_RSVD]   = 1'b0;

  // per-bit next values keep a single process on the mirror register
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_hv
      // cyclic input: keep the last sample until the next sampling instant
      assign level_nxt[`WSS_BIT_HV1_LVL + gi] = (!hv_cyclic[gi] || hv_sample[gi])
        ? hv_pin_level[gi]
        : level_r[`WSS_BIT_HV1_LVL + gi];
    end
    // gp pins: no sampling scheme, refreshed only in allowed modes
    for (gi = 0; gi < 2; gi++)
    begin : g_gp
      assign level_nxt[`WSS_BIT_GP1_LVL + gi] =
        (gp_is_gpio[gi] && gp_level_cfg[gi] && mode_normal_or_stop)
        ? gp_pin_level[gi]
        : level_r[`WSS_BIT_GP1_LVL + gi];
    end
  endgenerate

  // pin levels are meaningless in reset, so the mirror simply starts at zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      level_r <= `WSS_RST_LEVEL;
    else
      level_r <= level_nxt;
  end

  // the first edge after reset still shows the reset value, hence the guard
  chk_dev_level: assert property (
    !$past(rst) |-> level_r[`WSS_BIT_DEV_MODE] == $past(fail_output_test_pin))
    else $error("development mode level not mirrored");

  chk_int_pullup: assert property (
    !$past(rst) |-> level_r[`WSS_BIT_INT_PULLUP] == $past(interrupt_pullup_config))
    else $error("interrupt pull-up level not mirrored");

  chk_hv_cyclic: assert property (
    hv_cyclic[0] && !hv_sample[0] |=> $stable(level_r[0]))
    else $error("cyclic level changed between samples");

  chk_hv_live: assert property (
    !hv_cyclic[2] |=> level_r[2] == $past(hv_pin_level[2]))
    else $error("static wake input level not mirrored");

  chk_gp_hold: assert property (
    !mode_normal_or_stop |=> $stable(level_r[5:4]))
    else $error("gp level refreshed outside normal or stop");

  cov_hv_sample: cover property (
    hv_cyclic[1] && hv_sample[1] && (hv_pin_level[1] != level_r[1]));

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------

  logic [7:0] rd_mux;

  // unmapped addresses answer zero
  always_comb
  begin
    case (reg_addr)
      `WSS_ADDR_WAKE_A:   rd_mux = wake_a_r;
      `WSS_ADDR_WAKE_B:   rd_mux = wake_b_r;
      `WSS_ADDR_LEVEL:    rd_mux = level_r & `WSS_MASK_LEVEL;
      `WSS_ADDR_OVERLOAD: rd_mux = overload_r;
      `WSS_ADDR_OPENLOAD: rd_mux = open_load_r;
      default:            rd_mux = 8'h00;
    endcase
  end

  // data is captured before the clear takes effect
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      reg_rdata_r  <= 8'h00;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
        reg_rdata_r <= rd_mux;
    end
  end

  chk_rsvd_zero: assert property (
    reg_rvalid_r && $past(reg_addr) == `WSS_ADDR_LEVEL |-> !reg_rdata_r[3])
    else $error("reserved level bit read as one");

  // ---------------------------------------------------------------
  // mode side effects
  // ---------------------------------------------------------------

  // comparator only meaningful while the transceiver is powered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      can_uv_comp_en_r <= 1'b0;
    else
      can_uv_comp_en_r <= can_mode_bit;
  end

  chk_uv_enable: assert property (
    !$past(rst) |-> can_uv_comp_en_r == $past(can_mode_bit))
    else $error("uv comparator enable does not follow mode bit");

  // pending wake flags turn a sleep request into a restart
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sleep_ok_r      <= 1'b0;
      sleep_restart_r <= 1'b0;
    end
    else
    begin
      sleep_ok_r      <= sleep_req && ~|{wake_a_r, wake_b_r};
      sleep_restart_r <= sleep_req && |{wake_a_r, wake_b_r};
    end
  end

  // exactly one answer per request, chosen by the pending flags
  chk_sleep_refuse: assert property (
    sleep_req && (|wake_b_r) |=> sleep_restart_r && !sleep_ok_r)
    else $error("sleep granted with wake flags pending");

  chk_sleep_grant: assert property (
    sleep_req && !(|{wake_a_r, wake_b_r}) |=> sleep_ok_r && !sleep_restart_r)
    else $error("sleep refused with no wake flags pending");

  cov_sleep_ok: cover property (sleep_req ##1 sleep_ok_r);


endmodule : wss_bank

// file: testbench/wss_host.sv
// host model that issues random status register reads
`timescale 1ns/1ps

module wss_host
(
  // clock and enable
  input  wire logic clk,
  input  wire logic en,
  // read request towards the bank
  output logic       reg_rd = 1'b0,
  output logic [6:0] reg_addr = 7'h00
);
  // ----------
  // read issue
  // ----------
  localparam logic [6:0] AMAP [6] = '{7'h46, 7'h47, 7'h48, 7'h54, 7'h55, 7'h3A};

  // one-cycle strobes, often back to back; the address is redrawn every cycle
  // from six entries and may repeat, so a held address is not guaranteed
  always @(posedge clk)
  begin
    reg_rd   <= en && ($urandom % 3 == 0);
    reg_addr <= AMAP[$urandom % 6];
  end
endmodule : wss_host

// file: testbench/testbench.sv
// self-checking bench for the wake and switch status bank
`timescale 1ns/1ps

module testbench;
  import wss_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         soft_rst = 1'b0;
  logic         host_en = 1'b0;
  logic         reg_rd;
  logic [6:0]   reg_addr;
  logic [7:0]   reg_rdata_r;
  logic         reg_rvalid_r, can_uv_comp_en_r, sleep_ok_r, sleep_restart_r;
  wss_wake_ev_t wake_ev = '0;
  wss_fault_t   fault = '0;
  logic         fail_output_test_pin = 1'b0, interrupt_pullup_config = 1'b0;
  logic [2:0]   hv_pin_level = '0, hv_cyclic = '0, hv_sample = '0;
  logic [1:0]   gp_pin_level = '0, gp_is_gpio = '0, gp_level_cfg = '0;
  logic         mode_normal_or_stop = 1'b0, can_mode_bit = 1'b0, sleep_req = 1'b0;
  int           n_errors = 0;
  int           n_compared = 0;
  int           m [5];
  int           o [5];
  int           k;

  wss_host host (.clk, .en(host_en), .reg_rd, .reg_addr);
  wss_bank uut (.clk, .rst, .soft_rst, .reg_rd, .reg_addr, .reg_rdata_r, .reg_rvalid_r,
    .wake_ev, .fault, .fail_output_test_pin, .interrupt_pullup_config, .hv_pin_level,
    .hv_cyclic, .hv_sample, .gp_pin_level, .gp_is_gpio, .gp_level_cfg,
    .mode_normal_or_stop, .can_mode_bit, .sleep_req, .can_uv_comp_en_r, .sleep_ok_r,
    .sleep_restart_r);

  initial forever #5 clk = ~clk;

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wrap_up;
    if (n_errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  function automatic int idx(input logic [6:0] a);
    case (a)
      7'h46: return 0;
      7'h47: return 1;
      7'h48: return 2;
      7'h54: return 3;
      7'h55: return 4;
      default: return 5;
    endcase
  endfunction : idx

  // -----
  // model
  // -----
  // m holds the five registers, o the expected outputs; pre-edge values
  // are used for the read data and the sleep answer
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      m = '{default: 0};
      o = '{default: 0};
    end
    else
    begin
      k = idx(reg_addr);
      o[1] = reg_rd;
      o[2] = sleep_req && (m[0] | m[1]) == 0;
      o[3] = sleep_req && (m[0] | m[1]) != 0;
      o[4] = can_mode_bit;
      if (reg_rd)
        o[0] = (k < 5) ? m[k] : 0;
      // read clears first so a same-cycle event survives
      if (reg_rd && k != 2 && k < 5)
        m[k] = 0;
      m[0] |= {1'b0, wake_ev.lin, wake_ev.can, wake_ev.timer, 1'b0, wake_ev.hv};
      m[1] |= {2'b00, wake_ev.gp, 4'h0};
      m[3] |= fault.overload;
      m[4] |= fault.open_load;
      if (soft_rst)
        m = '{0, 0, m[2], 0, 0};
      for (int i = 0; i < 3; i++)
        if (!hv_cyclic[i] || hv_sample[i])
          m[2][i] = hv_pin_level[i];
      for (int i = 0; i < 2; i++)
        if (gp_is_gpio[i] && gp_level_cfg[i] && mode_normal_or_stop)
          m[2][i + 4] = gp_pin_level[i];
      m[2][7] = fail_output_test_pin;
      m[2][6] = interrupt_pullup_config;
    end
  end

  // outputs are settled by the falling edge
  always @(negedge clk)
  begin
    chk("rdata", reg_rdata_r, o[0]);
    chk("rvalid", reg_rvalid_r, o[1]);
    chk("sleep_ok", sleep_ok_r, o[2]);
    chk("sleep_restart", sleep_restart_r, o[3]);
    chk("uv_enable", can_uv_comp_en_r, o[4]);
  end

  // --------
  // stimulus
  // --------
  // sparse events keep flags mostly clear so read clearing is visible;
  // a second reset lands in mid-run
  initial
  begin
    void'($urandom(32'h23E40A64));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (int j = 0; j < 4000; j++)
    begin
      @(posedge clk);
      rst <= (j % 2000 > 1990);
      host_en <= (j % 2000 < 1989) && j > 0;
      wake_ev <= ($urandom % 6 == 0) ? wss_wake_ev_t'(8'(1 << ($urandom % 8))) : '0;
      fault <= ($urandom % 8 == 0) ? wss_fault_t'(8'($urandom)) : '0;
      {fail_output_test_pin, interrupt_pullup_config, hv_pin_level, gp_pin_level}
        <= 7'($urandom);
      {hv_cyclic, hv_sample, gp_is_gpio, gp_level_cfg, mode_normal_or_stop}
        <= 11'($urandom);
      can_mode_bit <= 1'($urandom);
      sleep_req <= ($urandom % 12 == 0);
      soft_rst <= ($urandom % 64 == 0);
    end
    repeat (3) @(posedge clk);
    wrap_up();
  end

  // watchdog cuts a hang short
  initial
  begin
    #100000;
    n_errors++;
    wrap_up();
  end
endmodule : testbench
